/* core/power_state_pkg.sv */
package power_state_pkg;

  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int LV_WAKE_US = 200;
  localparam int LV_WAKE_CYC =
    (LV_WAKE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 12;

  // clock ceilings in MHz
  localparam logic [7:0] FULL_MAX_MHZ = 8'hb4;
  localparam logic [7:0] REDUCED_MAX_MHZ = 8'h5a;
  localparam logic [7:0] LV075_MAX_MHZ = 8'h14;
  localparam logic [7:0] LV105_MAX_MHZ = 8'h20;

  // pin groups: 30 general, 11 low-power, 4 battery
  localparam logic [29:0] GPIO_ALL = 30'h3fff_ffff;
  localparam logic [10:0] LPGPIO_ALL = 11'h7ff;
  localparam logic [3:0] BATT_ALL = 4'hf;

  // wakeup source masks, bit order of wake_src_s
  localparam logic [21:0] WAKE_STANDBY = 22'h3f_e7b9;
  localparam logic [21:0] WAKE_SLEEP_HI = 22'h3f_a000;
  localparam logic [21:0] WAKE_SLEEP_LV = 22'h3f_8000;
  localparam logic [21:0] WAKE_CPU_OFF = 22'h00_4010;
  localparam logic [21:0] WAKE_SHUTDOWN = 22'h3f_8000;

  typedef enum logic [3:0] {
    FULL_POWER_ACTIVE = 4'b0000,
    REDUCED_VOLTAGE_ACTIVE = 4'b0001,
    LOW_VOLTAGE_ACTIVE = 4'b0010,
    CPU_OFF_PERIPHERAL_RUN = 4'b0011,
    STANDBY_FULL = 4'b0100,
    STANDBY_REDUCED = 4'b0101,
    STANDBY_LOW = 4'b0110,
    SLEEP_FULL = 4'b0111,
    SLEEP_REDUCED = 4'b1000,
    SLEEP_LOW = 4'b1001,
    SHUTDOWN_STATE = 4'b1010,
    WAKING_LOW = 4'b1011
  } pstate_e;

  typedef enum logic [2:0] {
    REQ_WAIT_IRQ = 3'b000,
    REQ_SLEEP = 3'b001,
    REQ_CPU_OFF = 3'b010,
    REQ_SHUTDOWN = 3'b011,
    REQ_GO_FULL = 3'b100,
    REQ_GO_REDUCED = 3'b101,
    REQ_GO_LV = 3'b110
  } req_op_e;

  typedef enum logic [1:0] {
    MEM_ON = 2'b00,
    MEM_RETAIN = 2'b01,
    MEM_OFF = 2'b10
  } mem_mode_e;

  typedef enum logic [1:0] {
    SUP_LDO_115 = 2'b00,
    SUP_LDO_105 = 2'b01,
    SUP_SCDC_105 = 2'b10,
    SUP_LDO_075 = 2'b11
  } supply_e;

  typedef struct packed {
    logic always_on_battery_gpio;
    logic watchdog;
    logic deep_sleep_timer;
    logic alarm;
    logic second_tick;
    logic msec_tick;
    logic system_rtc_block;
    logic sensor_data_collector;
    logic wireless_cpu;
    logic comparator;
    logic brownout_detector;
    logic lp_gpio_group;
    logic lp_gpio_pin;
    logic lp_ssi;
    logic lp_i2s;
    logic lp_i2c;
    logic lp_uart;
    logic lp_adc_dac;
    logic lp_dma;
    logic lp_gpio_wake;
    logic touch;
    logic lp_timer;
  } wake_src_s;

  typedef struct packed {
    logic valid;
    req_op_e op;
  } sw_req_s;

  typedef struct packed {
    pstate_e state;
    logic cpu_clk_gated;
    logic cpu_pwr_gated;
    logic cpu_clk_lp_bus;
    logic [7:0] cpu_clk_max_mhz;
    supply_e supply;
    logic [29:0] gpio_en;
    logic [10:0] low_power_gpio_en;
    logic [3:0] always_on_battery_gpio_en;
    mem_mode_e main_low_power_sram;
    mem_mode_e peripheral_side_sram;
    logic backup_retain;
    logic periph_cfg_reset;
    logic wake_busy;
  } power_out_s;

  // outputs of the full-power state, also the reset value
  localparam power_out_s FULL_OUT = '{
    state: FULL_POWER_ACTIVE,
    cpu_clk_gated: 1'b0,
    cpu_pwr_gated: 1'b0,
    cpu_clk_lp_bus: 1'b0,
    cpu_clk_max_mhz: FULL_MAX_MHZ,
    supply: SUP_LDO_115,
    gpio_en: GPIO_ALL,
    low_power_gpio_en: LPGPIO_ALL,
    always_on_battery_gpio_en: BATT_ALL,
    main_low_power_sram: MEM_ON,
    peripheral_side_sram: MEM_ON,
    backup_retain: 1'b0,
    periph_cfg_reset: 1'b0,
    wake_busy: 1'b0
  };

  typedef struct packed {
    logic busy;
    logic done;
    logic [TMR_W-1:0] count;
  } tmr_state_s;

  localparam tmr_state_s TMR_RESET = '{busy: 1'b0, done: 1'b0, count: '0};
  localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(LV_WAKE_CYC);
  localparam logic [TMR_W-1:0] TMR_ONE = 12'h001;

endpackage

/* core/wake_delay_timer.sv */
`timescale 1ns/10ps
module wake_delay_timer
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic start,
  output logic done
);
  import power_state_pkg::*;

  tmr_state_s r;
  tmr_state_s next_r;

  // load on start, count down, pulse done on the last count
  always_comb
  begin
    next_r = r;
    next_r.done = 1'b0;
    if (start)
    begin
      next_r.busy = 1'b1;
      next_r.count = TMR_LOAD;
    end
    else if (r.busy)
    begin
      if (r.count == TMR_ONE)
      begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end
      else
        next_r.count = r.count - TMR_ONE;
    end
  end

  // state register
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      r <= TMR_RESET;
    else
      r <= next_r;
  end

  assign done = r.done;

endmodule

/* core/mcu_power_state_controller.sv */
`timescale 1ns/10ps
module mcu_power_state_controller
(
  input wire logic ref_clk,
  input wire logic rstn,
  input power_state_pkg::sw_req_s sw_req,
  input wire logic lv_src_is_scdc,
  input wire logic sram_retain_req,
  input power_state_pkg::wake_src_s wake_enable,
  input power_state_pkg::wake_src_s wake_irq,
  input wire logic nested_irq_any,
  input wire logic periph_work_done,
  output power_state_pkg::power_out_s pout
);
  import power_state_pkg::*;

  typedef struct packed {
    pstate_e st;
    wake_src_s armed;
    logic lv_scdc;
    logic retain;
    power_out_s out;
  } ctl_state_s;

  ctl_state_s r;
  ctl_state_s next_r;
  logic tmr_done;
  logic hit;
  logic cfg_rst;
  logic tmr_kick;

  // true for the three states where software runs
  function automatic logic is_active(pstate_e st);
    is_active = (st == FULL_POWER_ACTIVE) ||
                (st == REDUCED_VOLTAGE_ACTIVE) ||
                (st == LOW_VOLTAGE_ACTIVE);
  endfunction

  // standby state matching an active state
  function automatic pstate_e standby_of(pstate_e st);
    unique case (st)
      FULL_POWER_ACTIVE: standby_of = STANDBY_FULL;
      REDUCED_VOLTAGE_ACTIVE: standby_of = STANDBY_REDUCED;
      default: standby_of = STANDBY_LOW;
    endcase
  endfunction

  // sleep state matching an active state
  function automatic pstate_e sleep_of(pstate_e st);
    unique case (st)
      FULL_POWER_ACTIVE: sleep_of = SLEEP_FULL;
      REDUCED_VOLTAGE_ACTIVE: sleep_of = SLEEP_REDUCED;
      default: sleep_of = SLEEP_LOW;
    endcase
  endfunction

  // sources able to wake each low-power state
  function automatic logic [21:0] wake_mask(pstate_e st);
    unique case (st)
      STANDBY_FULL, STANDBY_REDUCED, STANDBY_LOW:
        wake_mask = WAKE_STANDBY;
      SLEEP_FULL, SLEEP_REDUCED:
        wake_mask = WAKE_SLEEP_HI;
      SLEEP_LOW:
        wake_mask = WAKE_SLEEP_LV;
      CPU_OFF_PERIPHERAL_RUN:
        wake_mask = WAKE_CPU_OFF;
      SHUTDOWN_STATE:
        wake_mask = WAKE_SHUTDOWN;
      default:
        wake_mask = '0;
    endcase
  endfunction

  // per-state clocks, supplies, pins and memories
  function automatic power_out_s decode_out(pstate_e st, logic scdc,
                                            logic keep);
    power_out_s o;
    mem_mode_e held;
    o = FULL_OUT;
    held = keep ? MEM_RETAIN : MEM_OFF;
    o.state = st;
    unique case (st)
      FULL_POWER_ACTIVE, STANDBY_FULL:
        o.supply = SUP_LDO_115;
      REDUCED_VOLTAGE_ACTIVE, STANDBY_REDUCED:
      begin
        o.cpu_clk_max_mhz = REDUCED_MAX_MHZ;
        o.supply = SUP_LDO_105;
      end
      LOW_VOLTAGE_ACTIVE, STANDBY_LOW, WAKING_LOW, CPU_OFF_PERIPHERAL_RUN:
      begin
        o.cpu_clk_lp_bus = 1'b1;
        o.cpu_clk_max_mhz = scdc ? LV105_MAX_MHZ : LV075_MAX_MHZ;
        o.supply = scdc ? SUP_SCDC_105 : SUP_LDO_075;
        o.gpio_en = '0;
      end
      SLEEP_FULL, SLEEP_REDUCED, SLEEP_LOW, SHUTDOWN_STATE:
      begin
        o.cpu_pwr_gated = 1'b1;
        o.cpu_clk_max_mhz = '0;
        o.supply = SUP_SCDC_105;
        o.gpio_en = '0;
        o.low_power_gpio_en = '0;
        o.main_low_power_sram = held;
        o.peripheral_side_sram = held;
        o.backup_retain = 1'b1;
      end
      default:
        o = FULL_OUT;
    endcase
    if (st == STANDBY_FULL || st == STANDBY_REDUCED || st == STANDBY_LOW)
      o.cpu_clk_gated = 1'b1;
    if (st == CPU_OFF_PERIPHERAL_RUN)
    begin
      o.cpu_pwr_gated = 1'b1;
      o.cpu_clk_max_mhz = '0;
      o.main_low_power_sram = held;
      o.peripheral_side_sram = MEM_ON;
      o.backup_retain = 1'b1;
    end
    if (st == SHUTDOWN_STATE)
    begin
      o.main_low_power_sram = MEM_OFF;
      o.peripheral_side_sram = MEM_OFF;
    end
    if (st == WAKING_LOW)
    begin
      o.cpu_clk_gated = 1'b1;
      o.wake_busy = 1'b1;
    end
    return o;
  endfunction

  // low-voltage wake latency counter; loads on the edge that enters the
  // wake state, and its registered done adds one cycle to the wait
  wake_delay_timer u_wake_timer
  (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .start(tmr_kick),
    .done(tmr_done)
  );

  // armed interrupts that this state accepts
  assign hit = |(wake_irq & r.armed & wake_mask(r.st));

  // entry requests from software and exits on wakeup
  always_comb
  begin
    next_r = r;
    tmr_kick = 1'b0;
    cfg_rst = 1'b0;
    if (sw_req.valid && is_active(r.st))
    begin
      unique case (sw_req.op)
        REQ_WAIT_IRQ: next_r.st = standby_of(r.st);
        REQ_SLEEP: next_r.st = sleep_of(r.st);
        REQ_CPU_OFF:
        begin
          if (r.st == LOW_VOLTAGE_ACTIVE)
            next_r.st = CPU_OFF_PERIPHERAL_RUN;
        end
        REQ_SHUTDOWN: next_r.st = SHUTDOWN_STATE;
        REQ_GO_FULL: next_r.st = FULL_POWER_ACTIVE;
        REQ_GO_REDUCED: next_r.st = REDUCED_VOLTAGE_ACTIVE;
        REQ_GO_LV:
        begin
          next_r.st = LOW_VOLTAGE_ACTIVE;
          next_r.lv_scdc = lv_src_is_scdc;
        end
        default: next_r.st = r.st;
      endcase
      // wake and retention setup is taken at entry
      next_r.armed = wake_enable;
      next_r.retain = sram_retain_req;
    end
    else
    begin
      unique case (r.st)
        STANDBY_FULL:
        begin
          if (hit || nested_irq_any)
            next_r.st = FULL_POWER_ACTIVE;
        end
        STANDBY_REDUCED:
        begin
          if (hit || nested_irq_any)
            next_r.st = REDUCED_VOLTAGE_ACTIVE;
        end
        SLEEP_FULL, SHUTDOWN_STATE:
        begin
          if (hit)
          begin
            next_r.st = FULL_POWER_ACTIVE;
            cfg_rst = 1'b1;
          end
        end
        SLEEP_REDUCED:
        begin
          if (hit)
          begin
            next_r.st = REDUCED_VOLTAGE_ACTIVE;
            cfg_rst = 1'b1;
          end
        end
        STANDBY_LOW, SLEEP_LOW, CPU_OFF_PERIPHERAL_RUN:
        begin
          if (hit)
          begin
            next_r.st = WAKING_LOW;
            tmr_kick = 1'b1;
            cfg_rst = (r.st == SLEEP_LOW);
          end
          else if (r.st == CPU_OFF_PERIPHERAL_RUN && periph_work_done)
            next_r.st = SLEEP_LOW;
        end
        WAKING_LOW:
        begin
          if (tmr_done)
            next_r.st = LOW_VOLTAGE_ACTIVE;
        end
        default: next_r.st = r.st;
      endcase
    end
    next_r.out = decode_out(next_r.st, next_r.lv_scdc, next_r.retain);
    next_r.out.periph_cfg_reset = cfg_rst;
  end

  // state register; reset lands in full-power active
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      r.st <= FULL_POWER_ACTIVE;
      r.armed <= '0;
      r.lv_scdc <= 1'b0;
      r.retain <= 1'b0;
      r.out <= FULL_OUT;
    end
    else
      r <= next_r;
  end

  assign pout = r.out;

  // cycles spent waiting in the wake state
  localparam int WAKE_LAST = LV_WAKE_CYC;
  logic [TMR_W-1:0] wake_cnt;
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      wake_cnt <= '0;
    else if (r.st == WAKING_LOW)
      wake_cnt <= wake_cnt + TMR_ONE;
    else
      wake_cnt <= '0;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  sequence wfi_from_full;
    sw_req.valid && sw_req.op == REQ_WAIT_IRQ && r.st == FULL_POWER_ACTIVE;
  endsequence

  sequence in_standby_full;
    pout.state == STANDBY_FULL && pout.cpu_clk_gated && !pout.cpu_pwr_gated;
  endsequence

  a_lv_ldo_clk: assert property (
    pout.state == LOW_VOLTAGE_ACTIVE && !r.lv_scdc
      |-> pout.cpu_clk_max_mhz == 8'h14)
    else $error("low-voltage clock ceiling wrong on ldo");

  a_lv_scdc_clk: assert property (
    pout.state == LOW_VOLTAGE_ACTIVE && r.lv_scdc
      |-> pout.cpu_clk_max_mhz == 8'h20 && pout.supply == SUP_SCDC_105)
    else $error("low-voltage clock ceiling wrong on converter");

  a_lv_clk_src: assert property (
    pout.state == LOW_VOLTAGE_ACTIVE |-> pout.cpu_clk_lp_bus)
    else $error("low-voltage state not on low-power bus clock");

  a_lv_gpio_set: assert property (
    pout.state inside {LOW_VOLTAGE_ACTIVE, CPU_OFF_PERIPHERAL_RUN}
      |-> pout.gpio_en == '0 && &pout.low_power_gpio_en
          && &pout.always_on_battery_gpio_en)
    else $error("wrong pin set in low-voltage states");

  a_lv_wake_time: assert property (
    pout.state == LOW_VOLTAGE_ACTIVE && $past(r.st) == WAKING_LOW
      |-> $past(wake_cnt) == TMR_W'(WAKE_LAST))
    else $error("low-voltage wake latency off");

  a_cpuoff_entry: assert property (
    r.st == CPU_OFF_PERIPHERAL_RUN && $past(r.st) != CPU_OFF_PERIPHERAL_RUN
      |-> $past(r.st) == LOW_VOLTAGE_ACTIVE && $past(sw_req.valid))
    else $error("processor-off entered from wrong state");

  a_cpuoff_power: assert property (
    pout.state == CPU_OFF_PERIPHERAL_RUN
      |-> pout.cpu_pwr_gated && pout.peripheral_side_sram == MEM_ON)
    else $error("processor-off power or sram wrong");

  a_wfi_standby: assert property (
    wfi_from_full |=> in_standby_full)
    else $error("wait-for-interrupt did not enter standby");

  a_sleep_cfg_rst: assert property (
    r.st inside {SLEEP_FULL, SLEEP_REDUCED, SHUTDOWN_STATE}
      && is_active(next_r.st) |=> pout.periph_cfg_reset)
    else $error("no configuration reset on sleep exit");

  a_shutdown_mem: assert property (
    pout.state == SHUTDOWN_STATE |-> pout.main_low_power_sram == MEM_OFF
      && pout.peripheral_side_sram == MEM_OFF && pout.backup_retain)
    else $error("memory kept in shutdown");

  a_illegal_kept: assert property (
    sw_req.valid && sw_req.op == REQ_CPU_OFF
      && r.st == FULL_POWER_ACTIVE |=> r.st == FULL_POWER_ACTIVE)
    else $error("illegal request changed state");

endmodule

/* testbench/wake_source_model.sv */
`timescale 1ns/10ps
module wake_source_model
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic raise,
  input wire logic raise_nested,
  input power_state_pkg::wake_src_s pattern,
  input power_state_pkg::pstate_e cur_state,
  output power_state_pkg::wake_src_s wake_irq,
  output logic nested_irq_any
);
  import power_state_pkg::*;
  logic cpu_up;

  // software on a running processor services every pending source
  assign cpu_up = cur_state inside {FULL_POWER_ACTIVE,
    REDUCED_VOLTAGE_ACTIVE, LOW_VOLTAGE_ACTIVE};

  // level sources stay up until serviced, so a slow wake is never lost
  always_ff @(posedge ref_clk)
  begin
    if (!rstn || cpu_up)
    begin
      wake_irq <= '0;
      nested_irq_any <= 1'b0;
    end
    else if (raise)
    begin
      wake_irq <= wake_irq | pattern;
      nested_irq_any <= nested_irq_any | raise_nested;
    end
  end
endmodule

/* testbench/tb.sv */
`timescale 1ns/10ps
module tb;
  import power_state_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  sw_req_s sw_req = '0;
  logic lv_src_is_scdc = 1'b0;
  logic sram_retain_req = 1'b0;
  wake_src_s wake_enable = '1;
  wake_src_s wake_irq;
  logic nested_irq_any;
  logic periph_work_done = 1'b0;
  power_out_s pout;
  logic raise = 1'b0;
  logic raise_nested = 1'b0;
  wake_src_s pattern = '0;
  int error_cnt = 0;
  int total_checks = 0;

  mcu_power_state_controller dut
  (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .sw_req(sw_req),
    .lv_src_is_scdc(lv_src_is_scdc),
    .sram_retain_req(sram_retain_req),
    .wake_enable(wake_enable),
    .wake_irq(wake_irq),
    .nested_irq_any(nested_irq_any),
    .periph_work_done(periph_work_done),
    .pout(pout)
  );

  wake_source_model irq_src
  (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .raise(raise),
    .raise_nested(raise_nested),
    .pattern(pattern),
    .cur_state(pout.state),
    .wake_irq(wake_irq),
    .nested_irq_any(nested_irq_any)
  );

  // 10 MHz reference clock
  always #50 ref_clk = ~ref_clk;

  // inputs move 1 ns after each rising edge
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp,
    input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // one request held for exactly one edge
  task automatic req(input req_op_e op);
    sw_req.valid = 1'b1;
    sw_req.op = op;
    tick();
    sw_req.valid = 1'b0;
  endtask

  task automatic fire(input wake_src_s p, input logic n);
    pattern = p;
    raise_nested = n;
    raise = 1'b1;
    tick();
    raise = 1'b0;
    raise_nested = 1'b0;
  endtask

  // bounded wait for a state, n counts edges; a lost wake ends the run
  task automatic wait_state(input pstate_e s, input int lim, output int n);
    n = 0;
    while (pout.state !== s)
    begin
      if (n == lim)
      begin
        error_cnt++;
        $display("MISMATCH wait expected %h seen %h", s, pout.state);
        wrap_up();
      end
      tick();
      n++;
    end
  endtask

  // low-side exit through the timed wake phase
  task automatic wake_low(input logic cfg);
    int n;
    wait_state(WAKING_LOW, 3, n);
    chk("waking latency", 1, n);
    chk("waking busy", 1, pout.wake_busy);
    chk("waking cfg reset", cfg, pout.periph_cfg_reset);
    wait_state(LOW_VOLTAGE_ACTIVE, 2100, n);
    chk("lv wake time", LV_WAKE_CYC + 1, n);
  endtask

  task automatic t_standby_hi;
    wake_src_s p;
    int n;
    p = '0;
    p.wireless_cpu = 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      req(req_op_e'(4 + i));
      req(REQ_WAIT_IRQ);
      chk("standby", 4 + i, pout.state);
      chk("standby gate", 2'b10,
        {pout.cpu_clk_gated, pout.cpu_pwr_gated});
      req(REQ_SHUTDOWN);
      chk("req in standby", 4 + i, pout.state);
      fire('0, 1'b1);
      wait_state(pstate_e'(i), 3, n);
      chk("nested irq wake", 1, n);
      req(REQ_WAIT_IRQ);
      fire(p, 1'b0);
      wait_state(pstate_e'(i), 3, n);
      chk("wireless wake", 1, n);
    end
  endtask

  task automatic t_low_voltage;
    wake_src_s p;
    p = '0;
    p.lp_timer = 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      lv_src_is_scdc = i[0];
      req(REQ_GO_LV);
      chk("lv max", i == 0 ? 8'h14 : 8'h20, pout.cpu_clk_max_mhz);
      chk("lv bus clock", 1, pout.cpu_clk_lp_bus);
      chk("lv gpio", 0, pout.gpio_en);
      chk("lv pins", 15'h7fff,
        {pout.low_power_gpio_en, pout.always_on_battery_gpio_en});
      req(REQ_GO_FULL);
    end
    req(REQ_GO_LV);
    req(REQ_WAIT_IRQ);
    chk("lv standby", STANDBY_LOW, pout.state);
    fire(p, 1'b0);
    wake_low(1'b0);
  endtask

  task automatic t_cpu_off;
    wake_src_s p;
    supply_e lv_sup;
    p = '0;
    {p.watchdog, p.comparator, p.brownout_detector} = 3'h7;
    {p.lp_i2c, p.touch, p.lp_timer, p.wireless_cpu} = 4'hf;
    req(REQ_GO_FULL);
    req(REQ_CPU_OFF);
    chk("cpu off from full", FULL_POWER_ACTIVE, pout.state);
    sram_retain_req = 1'b1;
    req(REQ_GO_LV);
    lv_sup = pout.supply;
    req(REQ_CPU_OFF);
    chk("cpu off", CPU_OFF_PERIPHERAL_RUN, pout.state);
    chk("cpu off power", 1, pout.cpu_pwr_gated);
    chk("cpu off supply", lv_sup, pout.supply);
    chk("cpu off sram", {MEM_RETAIN, MEM_ON},
      {pout.main_low_power_sram, pout.peripheral_side_sram});
    chk("cpu off backup", 1, pout.backup_retain);
    chk("cpu off pins", 15'h7fff,
      {pout.low_power_gpio_en, pout.always_on_battery_gpio_en});
    fire(p, 1'b0);
    repeat (4) tick();
    chk("cpu off held", CPU_OFF_PERIPHERAL_RUN, pout.state);
    p = '0;
    p.sensor_data_collector = 1'b1;
    fire(p, 1'b0);
    wake_low(1'b0);
    req(REQ_CPU_OFF);
    p = '0;
    p.lp_adc_dac = 1'b1;
    fire(p, 1'b0);
    wake_low(1'b0);
    sram_retain_req = 1'b0;
    req(REQ_CPU_OFF);
    periph_work_done = 1'b1;
    tick();
    periph_work_done = 1'b0;
    chk("work done sleep", SLEEP_LOW, pout.state);
    chk("lv sleep sram", {MEM_OFF, MEM_OFF},
      {pout.main_low_power_sram, pout.peripheral_side_sram});
    p = '0;
    p.wireless_cpu = 1'b1;
    fire(p, 1'b0);
    repeat (4) tick();
    chk("lv sleep held", SLEEP_LOW, pout.state);
    p.watchdog = 1'b1;
    fire(p, 1'b0);
    wake_low(1'b1);
  endtask

  task automatic t_sleep_hi;
    wake_src_s p;
    int n;
    p = '0;
    p.wireless_cpu = 1'b1;
    sram_retain_req = 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      req(req_op_e'(4 + i));
      req(REQ_SLEEP);
      chk("sleep", 7 + i, pout.state);
      chk("sleep gpio", 0, pout.gpio_en);
      chk("sleep pins", 15'h000f,
        {pout.low_power_gpio_en, pout.always_on_battery_gpio_en});
      chk("sleep sram", {MEM_RETAIN, MEM_RETAIN},
        {pout.main_low_power_sram, pout.peripheral_side_sram});
      chk("sleep backup", 1, pout.backup_retain);
      fire(p, 1'b0);
      wait_state(pstate_e'(i), 3, n);
      chk("sleep wake", 1, n);
      chk("cfg reset", 1, pout.periph_cfg_reset);
      tick();
      chk("cfg reset end", 0, pout.periph_cfg_reset);
    end
  endtask

  task automatic t_shutdown;
    wake_src_s p;
    int n;
    wake_enable.alarm = 1'b0;
    for (int i = 1; i < 3; i++)
    begin
      req(req_op_e'(4 + i));
      req(REQ_SHUTDOWN);
      chk("shutdown", SHUTDOWN_STATE, pout.state);
      chk("shutdown power", 1, pout.cpu_pwr_gated);
      chk("shutdown sram", {MEM_OFF, MEM_OFF},
        {pout.main_low_power_sram, pout.peripheral_side_sram});
      chk("shutdown backup", 1, pout.backup_retain);
      p = '0;
      {p.alarm, p.sensor_data_collector} = 2'b11;
      fire(p, 1'b0);
      repeat (4) tick();
      chk("shutdown held", SHUTDOWN_STATE, pout.state);
      p = '0;
      p.msec_tick = 1'b1;
      fire(p, 1'b0);
      wait_state(FULL_POWER_ACTIVE, 3, n);
      chk("shutdown wake", 1, n);
      chk("shutdown cfg", 1, pout.periph_cfg_reset);
    end
    wake_enable = '1;
  endtask

  // main sequence: reset, scenarios, then a reset in mid-run
  initial
  begin
    repeat (16) tick();
    rstn = 1'b1;
    chk("reset state", FULL_POWER_ACTIVE, pout.state);
    chk("reset max", 8'hb4, pout.cpu_clk_max_mhz);
    chk("reset gpio", 30'h3fff_ffff, pout.gpio_en);
    t_standby_hi();
    t_low_voltage();
    t_cpu_off();
    t_sleep_hi();
    t_shutdown();
    req(REQ_SLEEP);
    rstn = 1'b0;
    repeat (2) tick();
    rstn = 1'b1;
    chk("second reset", FULL_POWER_ACTIVE, pout.state);
    chk("second reset backup", 0, pout.backup_retain);
    wrap_up();
  end
endmodule
